/* File: sciu_pkg.sv */
// Package for the card interrupt unit: register map, field layout, types
// ------------------------------------------------------------------
// ------------------------------------------------------------------
package sciu_pkg;

  // ------------------------------------------------------------------
  // Register map: printed offsets are not multiples of four, so they are indices
  // ------------------------------------------------------------------
  localparam logic [7:0] SCIU_IDX_SELECT = 8'h00_AB;
  localparam logic [7:0] SCIU_IDX_IRQ = 8'h00_AE;
  localparam logic [11:0] SCIU_ADDR_SELECT = {2'b00, SCIU_IDX_SELECT, 2'b00};
  localparam logic [11:0] SCIU_ADDR_IRQ = {2'b00, SCIU_IDX_IRQ, 2'b00};

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int SCIU_BIT_TBE = 7;
  localparam int SCIU_BIT_RSVD = 6;
  localparam int SCIU_BIT_OVC = 5;
  localparam int SCIU_BIT_VERR = 4;
  localparam int SCIU_BIT_WTO = 3;
  localparam int SCIU_BIT_SENT = 2;
  localparam int SCIU_BIT_RECV = 1;
  localparam int SCIU_BIT_PAR = 0;
  localparam int SCIU_BIT_BANK = 0;
  localparam logic [7:0] SCIU_EVT_MASK = 8'h00_BF;
  localparam logic [7:0] SCIU_SEL_MASK = 8'h00_5F;
  localparam logic [7:0] SCIU_FLAG_RST = 8'h00_00;
  localparam logic [7:0] SCIU_EN_RST = 8'h00_00;
  localparam logic [7:0] SCIU_SEL_RST = 8'h00_08;
  localparam logic [2:0] SCIU_SRC_NONE = 3'h7;

  // Event strobes from the card interface, one cycle each
  typedef struct packed {
    logic tx_buffer_empty;
    logic current_overflow;
    logic voltage_error;
    logic waiting_timeout;
    logic char_sent;
    logic char_received;
    logic parity_error;
  } sciu_events_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sciu_apb_req_t;

  // Decoded register access, valid in the access cycle
  typedef struct packed {
    logic wr_sel;
    logic wr_irq;
    logic rd_irq;
    logic err;
  } sciu_acc_t;

  // Flatten events into the register layout; bit 6 stays zero
  function automatic logic [7:0] sciu_pack(input sciu_events_t e);
    logic [7:0] v;
    v = 8'h00_00;
    v[SCIU_BIT_TBE] = e.tx_buffer_empty;
    v[SCIU_BIT_OVC] = e.current_overflow;
    v[SCIU_BIT_VERR] = e.voltage_error;
    v[SCIU_BIT_WTO] = e.waiting_timeout;
    v[SCIU_BIT_SENT] = e.char_sent;
    v[SCIU_BIT_RECV] = e.char_received;
    v[SCIU_BIT_PAR] = e.parity_error;
    return v;
  endfunction

endpackage

/* File: sciu_apb_decode.sv */
// APB address decode for the card interrupt unit
`timescale 1ns/1ns
module sciu_apb_decode
  import sciu_pkg::*;
(
  input wire sciu_apb_req_t req,
  input wire logic bank_sel,
  output sciu_acc_t acc
);

  // Access phase only; one shared offset split by the bank select bit
  always_comb begin
    acc = '0;
    if (req.psel && req.penable) begin
      if (req.paddr == SCIU_ADDR_SELECT) begin
        acc.wr_sel = req.pwrite;
      end else if (req.paddr == SCIU_ADDR_IRQ) begin
        acc.wr_irq = req.pwrite && bank_sel;
        acc.rd_irq = !req.pwrite && !bank_sel;
        acc.err = 1'b0;
      end else begin
        acc.err = 1'b1;
      end
    end
  end

endmodule

/* File: sciu_priority.sv */
// Priority encoder for pending card interrupt sources
`timescale 1ns/1ns
module sciu_priority
  import sciu_pkg::*;
(
  input wire logic [7:0] pending,
  output logic [2:0] source
);

  // Highest bit wins: buffer empty down to parity error; bit 6 never pends
  always_comb begin
    source = SCIU_SRC_NONE;
    for (int i = 0; i < 8; i++) begin
      if (pending[i] && i != SCIU_BIT_RSVD) begin
        source = 3'(i);
      end
    end
  end

endmodule

/* File: sciu_irq_unit.sv */
// Card UART interrupt flags, enables, bank select and APB slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module sciu_irq_unit
  import sciu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sciu_events_t events,
  output logic irq,
  output logic [2:0] irq_source,
  output logic [7:0] select_ctrl
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] select;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic [2:0] src;
  } sciu_state_t;

  sciu_state_t state_q;
  sciu_state_t state_d;
  sciu_apb_req_t req;
  sciu_acc_t acc;
  sciu_acc_t acc_fire;
  logic [7:0] set_vec;
  logic [7:0] pend_d;
  logic [2:0] src_d;

  // ------------------------------------------------------------------
  // Bus decode and priority
  // ------------------------------------------------------------------
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  sciu_apb_decode u_decode (
    .req(req),
    .bank_sel(state_q.select[SCIU_BIT_BANK]),
    .acc(acc)
  );

  sciu_priority u_prio (
    .pending(pend_d),
    .source(src_d)
  );

  // Parity error is only taken with a sent or received character
  always_comb begin
    set_vec = sciu_pack(events);
    set_vec[SCIU_BIT_PAR] = events.parity_error &&
                            (events.char_sent || events.char_received);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // One-wait slave: the first access cycle acts, pready rises in the next one, then drops
  always_comb begin
    state_d = state_q;
    acc_fire = acc;
    if (state_q.ready) begin
      acc_fire = '0; // Second access cycle is the completing one already seen
    end
    state_d.ready = psel && penable && !state_q.ready;
    state_d.err = acc_fire.err;
    state_d.rdata = 32'h0000_0000;
    if (psel && penable && !pwrite && !state_q.ready) begin
      if (paddr == SCIU_ADDR_SELECT) begin
        state_d.rdata = {24'h00_0000, state_q.select};
      end else if (paddr == SCIU_ADDR_IRQ) begin
        state_d.rdata = {24'h00_0000, state_q.select[SCIU_BIT_BANK] ?
                         state_q.enables : state_q.flags};
      end
    end
    // Reading the flags clears them; new events in that cycle survive
    state_d.flags = (acc_fire.rd_irq ? SCIU_FLAG_RST : state_q.flags) | set_vec;
    state_d.flags = state_d.flags & SCIU_EVT_MASK;
    // Flag register takes no writes; only the enable bank is writable
    if (acc_fire.wr_irq && pstrb[0]) begin
      state_d.enables = pwdata[7:0] & SCIU_EVT_MASK;
    end
    if (acc_fire.wr_sel && pstrb[0]) begin
      state_d.select = pwdata[7:0] & SCIU_SEL_MASK;
    end
    pend_d = state_d.flags & state_d.enables;
    state_d.irq = |pend_d;
    state_d.src = src_d;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= '0;
      state_q.flags <= SCIU_FLAG_RST;
      state_q.enables <= SCIU_EN_RST;
      state_q.select <= SCIU_SEL_RST;
      state_q.src <= SCIU_SRC_NONE;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops; pready too, so every access takes one wait cycle
  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.err;
  assign irq = state_q.irq;
  assign irq_source = state_q.src;
  assign select_ctrl = state_q.select;

endmodule

/* File: sciu_irq_unit_assertions.sv */
// Port checker for the card interrupt unit
`timescale 1ns/1ns
module sciu_irq_unit_checker
  import sciu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sciu_events_t events,
  input wire logic irq,
  input wire logic [2:0] irq_source,
  input wire logic [7:0] select_ctrl
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Access phase in progress
  wire acc = psel && penable;
  property p_wait; acc && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_clr; acc && !pready && !pwrite && paddr == SCIU_ADDR_IRQ && !select_ctrl[0]
    && events == '0 |=> !irq; endproperty
  a_clr: assert property (p_clr) else $error("request left after flag read");
  // Only an access can lower the request, so a lost flag shows here
  property p_hold; irq && !acc |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("request dropped on its own");
  property p_none; !irq |-> irq_source == SCIU_SRC_NONE; endproperty
  a_none: assert property (p_none) else $error("source without request");
  property p_err; pready |-> pslverr == !(paddr == SCIU_ADDR_SELECT || paddr == SCIU_ADDR_IRQ);
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_rsel; pready && !pwrite && paddr == SCIU_ADDR_SELECT |->
    prdata == {24'h00_0000, select_ctrl}; endproperty
  a_rsel: assert property (p_rsel) else $error("select readback wrong");
  property p_rsvd; pready && !pwrite && paddr == SCIU_ADDR_IRQ |->
    prdata[31:8] == 24'h00_0000 && !prdata[6]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
  property p_wsel; pready && pwrite && paddr == SCIU_ADDR_SELECT |=>
    {24'h00_0000, select_ctrl} == ($past(pwdata) & {24'h00_0000, SCIU_SEL_MASK}); endproperty
  a_wsel: assert property (p_wsel) else $error("select write lost");
  property p_rst; $fell(rst) |-> select_ctrl == SCIU_SEL_RST && !irq; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

/* File: sciu_irq_unit_bench.sv */
// Self-checking bench for the card interrupt unit
`timescale 1ns/1ns
module sciu_irq_unit_bench import sciu_pkg::*;;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rnd = 32'h4459_e5b3;
  logic pready, pslverr, irq, re;
  logic [2:0] irq_source;
  logic [7:0] select_ctrl, en, fl;
  logic [6:0] v;
  sciu_events_t events = '0;
  int fails = 0, checks_done = 0;
  sciu_irq_unit dut(.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .events, .irq, .irq_source, .select_ctrl);
  // Free-running core clock
  initial forever #20 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Parity only counts when it rides on a sent or received character
  function automatic logic [7:0] exp_fl(input logic [6:0] e);
    return {e[6], 1'b0, e[5:1], e[0] & (e[2] | e[1])};
  endfunction
  function automatic logic [2:0] prio(input logic [7:0] f);
    for (int i = 7; i >= 0; i--) if (f[i]) return 3'(i);
    return 3'h7;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    apb(0, SCIU_ADDR_SELECT, 0);
    chk(rd, 32'h0000_0008);
    chk(re, 0);
    apb(0, 12'h004, 0);
    chk(re, 1);
    // Reserved select bits must not stick; bank bit lands at bit 0
    apb(1, SCIU_ADDR_SELECT, 32'h0000_00FF);
    chk(select_ctrl, 8'h5F);
    apb(0, SCIU_ADDR_IRQ, 0);
    chk(rd, 0);
    chk(re, 0);
    $display("reset test done");
    // One-hot corners first, then random events against random enables
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      v = (i < 7) ? 7'h01 << i : rnd[6:0];
      en = (i < 7) ? 8'hFF : rnd[15:8];
      apb(1, SCIU_ADDR_SELECT, 1);
      apb(1, SCIU_ADDR_IRQ, en);
      apb(0, SCIU_ADDR_IRQ, 0);
      chk(rd, en & 8'hBF);
      apb(1, SCIU_ADDR_SELECT, 0);
      @(posedge core_clk);
      events <= sciu_events_t'(v);
      @(posedge core_clk);
      events <= '0;
      apb(1, SCIU_ADDR_IRQ, 32'hFF);
      fl = exp_fl(v);
      chk(irq, |(fl & en));
      chk(irq_source, (|(fl & en)) ? prio(fl & en) : 3'h7);
      apb(0, SCIU_ADDR_IRQ, 0);
      chk(rd, fl);
      chk(irq, 0);
    end
    $display("event test done");
    // Event landing in the very cycle that a read clears the flags
    fork
      apb(0, SCIU_ADDR_IRQ, 0);
      begin
        repeat (2) @(posedge core_clk);
        events <= sciu_events_t'(7'h40);
        @(posedge core_clk);
        events <= '0;
      end
    join
    chk(rd, 0);
    apb(0, SCIU_ADDR_IRQ, 0);
    chk(rd, 32'h0000_0080);
    $display("clear race test done");
    stop_test();
  end
  // Watchdog far beyond the roughly 1070 cycles the tests need
  initial begin
    #400000;
    fails++;
    stop_test();
  end
endmodule
bind sciu_irq_unit sciu_irq_unit_checker u_chk(.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .events, .irq, .irq_source, .select_ctrl);
